/* src/eas_seq_ctrl.sv */
// extended page, segment and register sequence control
`timescale 1ns/100ps
module eas_seq_ctrl
    import eas_pkg::*;
(
    input  wire logic                       ref_clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic                       instr_retire_i,
    input  wire logic [15:0]                instr_word0_i,
    input  wire logic [15:0]                instr_word1_i,
    input  wire logic [15:0]                reg_operand_i,
    input  wire logic                       class_b_trap_i,
    input  wire logic                       addr_req_i,
    input  wire logic [eas_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [eas_pkg::PAGE_W-1:0] data_page_pointer_i,
    output logic [eas_pkg::PHYS_W-1:0]      phys_addr_o,
    output logic                            phys_addr_valid_o,
    output logic                            ext_sfr_o,
    output logic                            irq_lock_o,
    output logic                            seq_active_o,
    output logic [eas_pkg::CNT_W-1:0]       seq_count_o
);
    import eas_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // instruction decode
    function automatic eas_mode_t decode_mode(input logic [15:0] w0);
        eas_mode_t m;
        m = SEQ_IDLE;
        if (w0[7:0] == OPC_IMM || w0[7:0] == OPC_REG)
        begin
            case (w0[SEL_MSB:SEL_LSB])
                SEL_PAGE:     m = SEQ_PAGE;
                SEL_PAGE_REG: m = SEQ_PAGE_REG;
                SEL_SEG:      m = SEQ_SEG;
                default:      m = SEQ_SEG_REG;
            endcase
        end
        else if (w0[7:0] == OPC_REG_ONLY && w0[SEL_MSB:SEL_LSB] == SEL_SEG)
        begin
            m = SEQ_REG;
        end
        return m;
    endfunction : decode_mode

    ////////////////////////////////////////////////////////////////////////////
    // mode classes, shared by the operand latch, translation and status
    function automatic logic is_page_mode(input eas_mode_t m);
        return (m == SEQ_PAGE) || (m == SEQ_PAGE_REG);
    endfunction : is_page_mode

    function automatic logic is_seg_mode(input eas_mode_t m);
        return (m == SEQ_SEG) || (m == SEQ_SEG_REG);
    endfunction : is_seg_mode

    function automatic logic is_ext_reg_mode(input eas_mode_t m);
        return (m == SEQ_PAGE_REG) || (m == SEQ_REG) || (m == SEQ_SEG_REG);
    endfunction : is_ext_reg_mode

    eas_mode_t             mode_ff;
    eas_mode_t             nxt_mode;
    eas_mode_t             dec_mode;
    logic [CNT_W-1:0]      cnt_ff;
    logic [CNT_W-1:0]      nxt_cnt;
    logic [PAGE_W-1:0]     page_ff;
    logic [PAGE_W-1:0]     nxt_page;
    logic                  reg_form;
    logic [PAGE_W-1:0]     op_page;
    logic                  seq_start;

    ////////////////////////////////////////////////////////////////////////////
    // operand selection for the retiring instruction
    always_comb
    begin
        dec_mode = decode_mode(instr_word0_i);
        reg_form = (instr_word0_i[7:0] == OPC_REG);
        // immediate page: low byte then two high bits; a segment is the low byte
        op_page  = reg_form ? reg_operand_i[PAGE_W-1:0]
                            : {instr_word1_i[9:8], instr_word1_i[7:0]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequence state
    always_comb
    begin
        nxt_mode = mode_ff;
        nxt_cnt  = cnt_ff;
        seq_start = 1'b0;
        // a trap wins over a start in the same cycle
        if (class_b_trap_i)
        begin
            nxt_mode = SEQ_IDLE;
            nxt_cnt  = CNT_RST;
        end
        // while running, sequence instructions are only counted, never nested
        else if (mode_ff != SEQ_IDLE)
        begin
            if (instr_retire_i)
            begin
                nxt_cnt = cnt_ff - 3'h1;
                if (cnt_ff == 3'h1)
                begin
                    nxt_mode = SEQ_IDLE;
                end
            end
        end
        else if (instr_retire_i && dec_mode != SEQ_IDLE)
        begin
            // armed at retirement so the very next instruction is covered
            nxt_mode = dec_mode;
            nxt_cnt  = {1'b0, instr_word0_i[CNT_MSB:CNT_LSB]} + 3'h1;
            seq_start = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            mode_ff <= SEQ_IDLE;
            cnt_ff  <= CNT_RST;
        end
        else
        begin
            mode_ff <= nxt_mode;
            cnt_ff  <= nxt_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // override operand, loaded only when a sequence is armed
    always_comb
    begin
        nxt_page = page_ff;
        if (seq_start)
        begin
            if (is_seg_mode(dec_mode))
            begin
                // a segment is one byte; the upper page bits read as zero
                nxt_page = {2'h0, op_page[SEG_W-1:0]};
            end
            else
            begin
                nxt_page = op_page;
            end
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            page_ff <= PAGE_RST;
        end
        else
        begin
            page_ff <= nxt_page;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address translation
    logic [PHYS_W-1:0] phys_ff;
    logic [PHYS_W-1:0] nxt_phys;
    logic              pvld_ff;
    logic              nxt_pvld;

    always_comb
    begin
        nxt_pvld = addr_req_i;
        if (is_page_mode(mode_ff))
        begin
            // page override keeps the in-page offset
            nxt_phys = {page_ff, addr_i[POFS_W-1:0]};
        end
        else if (is_seg_mode(mode_ff))
        begin
            // segment override takes the whole address as offset
            nxt_phys = {page_ff[SEG_W-1:0], addr_i};
        end
        else
        begin
            // page pointer path, also used by register-only runs
            nxt_phys = {data_page_pointer_i, addr_i[POFS_W-1:0]};
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            phys_ff <= 24'h000000;
            pvld_ff <= 1'b0;
        end
        else
        begin
            phys_ff <= nxt_phys;
            pvld_ff <= nxt_pvld;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status outputs, aligned with the registered mode
    logic              xsfr_ff;
    logic              nxt_xsfr;
    logic              lock_ff;
    logic              nxt_lock;

    always_comb
    begin
        nxt_xsfr = is_ext_reg_mode(nxt_mode);
        nxt_lock = (nxt_mode != SEQ_IDLE);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            xsfr_ff <= 1'b0;
            lock_ff <= 1'b0;
        end
        else
        begin
            xsfr_ff <= nxt_xsfr;
            lock_ff <= nxt_lock;
        end
    end

    assign phys_addr_o       = phys_ff;
    assign phys_addr_valid_o = pvld_ff;
    assign ext_sfr_o         = xsfr_ff;
    assign irq_lock_o        = lock_ff;
    assign seq_active_o      = lock_ff;
    assign seq_count_o       = cnt_ff;

endmodule : eas_seq_ctrl

/* inc/eas_pkg.sv */
// constants and types for the extended addressing sequence control
// Contract
// - The extended-page instruction is decoded from a 4-byte D7 form or a 2-byte DC form with selector bits 01.
// - The extended-page-and-register instruction is decoded from a D7 or DC form with selector bits 11.
// - In an extended-page sequence the 10-bit page A23-A14 of long or indirect addresses comes from the operand.
// - In an extended-page sequence the 14-bit offset A13-A0 comes from the address as usual.
// - In an extended-page-and-register sequence register accesses go to the extended register space.
// - While any sequence runs, interrupts, event channel transfers and class A traps are held off.
// - The extended-page-and-register length comes from its 2-bit count operand.
// - The extended-register-only length comes from its single 2-bit count operand, with no address override.
// - In an extended-register-only sequence register accesses go to the extended register space.
// - In an extended-segment sequence the 8-bit segment A23-A16 of long or indirect addresses is the operand.
// - In an extended-segment sequence the address itself is the 16-bit offset A15-A0.
// - The extended-segment override applies from the very next instruction.
// - The override lasts the 2-bit count operand plus one instructions (1 to 4) and ends early on a class B trap.
package eas_pkg;

    localparam logic [7:0] OPC_IMM      = 8'hd7;
    localparam logic [7:0] OPC_REG      = 8'hdc;
    localparam logic [7:0] OPC_REG_ONLY = 8'hd1;

    localparam logic [1:0] SEL_SEG      = 2'h0;
    localparam logic [1:0] SEL_PAGE     = 2'h1;
    localparam logic [1:0] SEL_SEG_REG  = 2'h2;
    localparam logic [1:0] SEL_PAGE_REG = 2'h3;

    localparam int SEL_MSB   = 15;
    localparam int SEL_LSB   = 14;
    localparam int CNT_MSB   = 13;
    localparam int CNT_LSB   = 12;
    localparam int PAGE_W    = 10;
    localparam int SEG_W     = 8;
    localparam int ADDR_W    = 16;
    localparam int PHYS_W    = 24;
    localparam int POFS_W    = 14;
    localparam int CNT_W     = 3;

    localparam logic [CNT_W-1:0]  CNT_RST  = 3'h0;
    localparam logic [PAGE_W-1:0] PAGE_RST = 10'h000;

    typedef enum logic [2:0] {
        SEQ_IDLE     = 3'b000,
        SEQ_PAGE     = 3'b001,
        SEQ_PAGE_REG = 3'b010,
        SEQ_REG      = 3'b011,
        SEQ_SEG      = 3'b100,
        SEQ_SEG_REG  = 3'b101
    } eas_mode_t;

endpackage : eas_pkg

/* dv/eas_checker.sv */
// checker for the extended addressing sequence control
`timescale 1ns/100ps
module eas_checker
    import eas_pkg::*;
(
    input wire logic                ref_clk_i,
    input wire logic                sys_rst_i,
    input wire logic                instr_retire_i,
    input wire logic                class_b_trap_i,
    input wire logic                addr_req_i,
    input wire logic [15:0]         instr_word0_i,
    input wire logic [15:0]         instr_word1_i,
    input wire logic [15:0]         reg_operand_i,
    input wire logic [15:0]         addr_i,
    input wire logic [PAGE_W-1:0]   data_page_pointer_i,
    input wire logic [PHYS_W-1:0]   phys_addr_o,
    input wire logic                phys_addr_valid_o,
    input wire logic                ext_sfr_o,
    input wire logic                irq_lock_o,
    input wire logic                seq_active_o,
    input wire logic [CNT_W-1:0]    seq_count_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic st = instr_retire_i && !seq_active_o && !class_b_trap_i;
    wire logic [7:0] op = instr_word0_i[7:0];
    wire logic [1:0] sl = instr_word0_i[SEL_MSB:SEL_LSB];
    property p_len; st && (op == OPC_IMM || op == OPC_REG)
        |=> seq_count_o == $past(instr_word0_i[13:12]) + 3'h1; endproperty
    a_len: assert property (p_len) else $error("bad length");
    property p_pg; st && op == OPC_IMM && sl == SEL_PAGE |=> seq_active_o && !ext_sfr_o; endproperty
    a_pg: assert property (p_pg) else $error("page start");
    property p_pr; st && op == OPC_REG && sl == SEL_PAGE_REG |=> ext_sfr_o; endproperty
    a_pr: assert property (p_pr) else $error("no ext regs");
    property p_tr; class_b_trap_i |=> !seq_active_o && !irq_lock_o; endproperty
    a_tr: assert property (p_tr) else $error("trap ignored");
    property p_ct; seq_active_o && instr_retire_i && !class_b_trap_i
        |=> seq_count_o == $past(seq_count_o) - 3'h1; endproperty
    a_ct: assert property (p_ct) else $error("bad count");
    property p_id; !seq_active_o |-> seq_count_o == 3'h0 && !ext_sfr_o && !irq_lock_o; endproperty
    a_id: assert property (p_id) else $error("idle state");
    property p_of; addr_req_i |=> phys_addr_valid_o && phys_addr_o[13:0] == $past(addr_i[13:0]);
    endproperty
    a_of: assert property (p_of) else $error("bad offset");
    property p_dp; addr_req_i && !seq_active_o
        |=> phys_addr_o[23:14] == $past(data_page_pointer_i); endproperty
    a_dp: assert property (p_dp) else $error("bad page");
    c_start: cover property (st && op == OPC_IMM);
    c_trap: cover property (class_b_trap_i && seq_active_o);
    c_xl: cover property (addr_req_i && seq_active_o);
endmodule : eas_checker
bind eas_seq_ctrl eas_checker u_chk (.*);

/* dv/eas_core_model.sv */
// core-side model: selected page pointer and register word
`timescale 1ns/100ps
module eas_core_model
    import eas_pkg::*;
(
    output logic [PAGE_W-1:0] dpp_o,
    output logic [15:0]       rw_o
);
    assign dpp_o = 10'h0c3;
    assign rw_o  = 16'h01e6;
endmodule : eas_core_model

/* dv/extended_addr_sequence_ctrl_tb.sv */
// self-checking bench for the extended addressing sequence control
`timescale 1ns/100ps
module extended_addr_sequence_ctrl_tb;
    import eas_pkg::*;
    logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, instr_retire_i = 1'b0, addr_req_i = 1'b0;
    logic class_b_trap_i = 1'b0;
    logic [15:0] instr_word0_i = 16'h0, addr_i = 16'h0, reg_operand_i;
    logic [15:0] instr_word1_i = 16'h02a5;
    logic [PAGE_W-1:0] data_page_pointer_i;
    logic [PHYS_W-1:0] phys_addr_o;
    logic phys_addr_valid_o, ext_sfr_o, irq_lock_o, seq_active_o;
    logic [CNT_W-1:0] seq_count_o;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    always #20 ref_clk_i = ~ref_clk_i;
    eas_core_model core (.dpp_o(data_page_pointer_i), .rw_o(reg_operand_i));
    eas_seq_ctrl uut (.ref_clk_i, .sys_rst_i, .instr_retire_i, .instr_word0_i, .instr_word1_i,
        .reg_operand_i, .class_b_trap_i, .addr_req_i, .addr_i, .data_page_pointer_i,
        .phys_addr_o, .phys_addr_valid_o, .ext_sfr_o, .irq_lock_o, .seq_active_o, .seq_count_o);
    task automatic step(input logic r, input logic [15:0] w, input logic q,
                        input logic [15:0] a);
        instr_retire_i = r;
        instr_word0_i  = w;
        addr_req_i     = q;
        addr_i         = a;
        @(posedge ref_clk_i) #1;
    endtask : step
    task automatic ck(input logic c, input string m);
        tests_run++;
        if (c !== 1'b1)
        begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : ck
    task automatic t_page;
        step(1'b1, {SEL_PAGE, 2'h1, 4'h0, OPC_IMM}, 1'b0, 16'h0);
        ck(seq_count_o === 3'h2 && irq_lock_o === 1'b1 && ext_sfr_o === 1'b0, "page start");
        step(1'b0, 16'h0, 1'b1, 16'hfedc);
        ck(phys_addr_o === {10'h2a5, 14'h3edc}, "page addr");
        step(1'b1, {SEL_PAGE_REG, 2'h3, 4'h0, OPC_REG}, 1'b0, 16'h0);
        step(1'b1, 16'h0, 1'b0, 16'h0);
        ck(seq_active_o === 1'b0 && ext_sfr_o === 1'b0, "page end");
        step(1'b0, 16'h0, 1'b1, 16'h4321);
        ck(phys_addr_o === {10'h0c3, 14'h0321}, "normal addr");
    endtask : t_page
    task automatic t_seg;
        step(1'b1, {SEL_SEG, 2'h0, 4'h0, OPC_IMM}, 1'b0, 16'h0);
        ck(seq_count_o === 3'h1, "seg start");
        step(1'b1, 16'h0, 1'b1, 16'hbeef);
        ck(phys_addr_o === 24'ha5beef && seq_active_o === 1'b0, "seg addr");
    endtask : t_seg
    task automatic t_sr;
        step(1'b1, {SEL_SEG_REG, 2'h1, 4'h0, OPC_REG}, 1'b0, 16'h0);
        ck(seq_count_o === 3'h2 && ext_sfr_o === 1'b1, "seg reg start");
        step(1'b1, 16'h0, 1'b1, 16'h1357);
        ck(phys_addr_o === 24'he61357 && seq_active_o === 1'b1, "seg reg addr");
        step(1'b1, 16'h0, 1'b0, 16'h0);
        ck(seq_active_o === 1'b0 && seq_count_o === 3'h0, "seg reg end");
        step(1'b1, {SEL_PAGE, 2'h0, 4'h0, OPC_REG}, 1'b0, 16'h0);
        ck(seq_count_o === 3'h1 && ext_sfr_o === 1'b0, "page reg form start");
        step(1'b1, 16'h0, 1'b1, 16'h2222);
        ck(phys_addr_o === {10'h1e6, 14'h2222}, "page reg form addr");
    endtask : t_sr
    task automatic t_reg;
        step(1'b1, {SEL_PAGE_REG, 2'h3, 4'h0, OPC_REG}, 1'b0, 16'h0);
        ck(seq_count_o === 3'h4 && ext_sfr_o === 1'b1, "page reg start");
        step(1'b0, 16'h0, 1'b1, 16'h0abc);
        ck(phys_addr_o === {10'h1e6, 14'h0abc}, "page reg addr");
        class_b_trap_i = 1'b1;
        step(1'b1, 16'h0, 1'b0, 16'h0);
        class_b_trap_i = 1'b0;
        ck(irq_lock_o === 1'b0 && ext_sfr_o === 1'b0, "trap end");
    endtask : t_reg
    task automatic t_ro;
        step(1'b1, {SEL_SEG, 2'h2, 4'h0, OPC_REG_ONLY}, 1'b0, 16'h0);
        ck(seq_count_o === 3'h3 && ext_sfr_o === 1'b1, "reg only start");
        step(1'b0, 16'h0, 1'b1, 16'h8765);
        ck(phys_addr_o === {10'h0c3, 14'h0765} && irq_lock_o === 1'b1, "reg only addr");
    endtask : t_ro
    task automatic wrap_up;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 200)
        begin
            errors++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (2) @(posedge ref_clk_i);
        #1 sys_rst_i = 1'b0;
        t_page();
        t_seg();
        t_reg();
        t_sr();
        t_ro();
        wrap_up();
    end
endmodule : extended_addr_sequence_ctrl_tb
